// *** core/tism_pkg.sv ***
// shared constants for the thermal interrupt status and mask block
package tism_pkg;
  localparam int ADDR_W = 12;
  localparam logic [7:0] CFG_IDX = 8'h40;
  localparam logic [7:0] STATUS_IDX = 8'h41;
  localparam logic [7:0] MASK_IDX = 8'h43;
  localparam logic [7:0] EVT_IDX = 8'h44;
  localparam logic [7:0] EVT_EN_IDX = 8'h45;
  localparam int B_INT_LIMIT = 0;
  localparam int B_REMOTE2_LIMIT = 1;
  localparam int B_REMOTE2_FAULT = 2;
  localparam int B_SPARE_LEVEL = 4;
  localparam int B_REMOTE1_LIMIT = 5;
  localparam int B_OVERHEAT_EXT = 6;
  localparam int B_REMOTE1_FAULT = 7;
  localparam int C_START = 0;
  localparam int C_INT_EN = 1;
  localparam int C_INT_CLR = 2;
  localparam int C_SOFT_RST = 4;
  localparam int C_POL_FLIP = 6;
  localparam logic [7:0] CFG_RESET = 8'h05;
  localparam logic [7:0] CFG_WMASK = 8'hC7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MASK_WMASK = 8'hF7;
  localparam logic [7:0] LATCHED_BITS = 8'hE7;
  localparam logic [7:0] EVT_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'h0, idx, 2'h0};
  endfunction
endpackage

// *** core/tism_reg_if.sv ***
// internal register access strobes between bus slave and register file
`timescale 1ns/1ps
interface tism_reg_if;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic wr_ok;
  logic rd_en;
  logic [11:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_ok;
  modport bus_side (output wr_en, wr_addr, wr_data, wr_lane0, rd_en, rd_addr,
    input wr_ok, rd_data, rd_ok);
  modport reg_side (input wr_en, wr_addr, wr_data, wr_lane0, rd_en, rd_addr,
    output wr_ok, rd_data, rd_ok);
endinterface

// *** core/tism_axil_slave.sv ***
// axi4-lite slave turning bus transfers into register strobes
`timescale 1ns/1ps
module tism_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  tism_reg_if.bus_side rb
);
  logic aw_full;
  logic w_full;
  logic [11:0] aw_q;
  logic [7:0] w_q;
  logic lane0_q;

  assign awready = !aw_full && !bvalid;
  assign wready = !w_full && !bvalid;
  assign arready = !rvalid;
  // write fires once both halves are held; response one cycle later
  assign rb.wr_en = aw_full && w_full && !bvalid;
  assign rb.wr_addr = aw_q;
  assign rb.wr_data = w_q;
  assign rb.wr_lane0 = lane0_q;
  assign rb.rd_en = arvalid && arready;
  assign rb.rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_q <= 12'h000;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      aw_q <= awaddr;
    end else if (rb.wr_en) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_q <= 8'h00;
      lane0_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_full <= 1'b1;
      w_q <= wdata[7:0];
      lane0_q <= wstrb[0];
    end else if (rb.wr_en) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= tism_pkg::RESP_OKAY;
    end else if (rb.wr_en) begin
      bvalid <= 1'b1;
      bresp <= rb.wr_ok ? tism_pkg::RESP_OKAY : tism_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= tism_pkg::RESP_OKAY;
    end else if (rb.rd_en) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rb.rd_data};
      rresp <= rb.rd_ok ? tism_pkg::RESP_OKAY : tism_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // tism_axil_slave

// *** core/tism_cause_latch.sv ***
// cause flags: latched error bits plus the live spare input level
`timescale 1ns/1ps
module tism_cause_latch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] cause_raw,
  input wire logic spare_level,
  input wire logic read_clear,
  input wire logic soft_clear,
  output logic [7:0] cause_flags
);
  logic [7:0] held;
  logic [7:0] next_held;

  // set wins over the clear-on-read so a coincident event is kept
  always_comb begin
    next_held = (cause_raw | (held & ~{8{read_clear}})) & tism_pkg::LATCHED_BITS;
    if (soft_clear) begin
      next_held = tism_pkg::STATUS_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held <= tism_pkg::STATUS_RESET;
    end else begin
      held <= next_held;
    end
  end

  // spare bit is never stored, a read cannot clear it
  always_comb begin
    cause_flags = held;
    cause_flags[tism_pkg::B_SPARE_LEVEL] = spare_level;
  end
endmodule // tism_cause_latch

// *** core/tism_top.sv ***
// thermal interrupt status and mask block with axi4-lite register access
// Contract
// - bit 0 flags internal sensor limit error
// - bit 1 flags remote two limit error
// - bit 2 flags remote two diode fault
// - bit 5 flags remote one limit error
// - bit 7 flags remote one diode fault
// - bit 6 flags externally driven overheat line
// - bit 4 is spare pin, optionally inverted
// - spare bit follows pin live, unlatched
// - status read never clears spare bit
// - status register resets to zero
// - mask bit one blocks its status bit
// - mask register resets to zero
// - alert output only when interrupts enabled
// - interrupt clear releases alert, keeps status
// - soft reset restores registers, self clears; the event and event enable registers keep their values
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tism_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic internal_limit_hit,
  input wire logic remote2_limit_hit,
  input wire logic remote2_diode_fault,
  input wire logic remote1_limit_hit,
  input wire logic remote1_diode_fault,
  input wire logic overheat_line_n,
  input wire logic overheat_self_drive,
  input wire logic spare_logic_input,
  output logic monitor_start,
  output logic alert_n,
  output logic irq
);
  tism_reg_if rb ();

  logic [7:0] cfg;
  logic [7:0] irq_cause_gate;
  logic [7:0] irq_cause_flags;
  logic [7:0] cause_raw;
  logic [7:0] evt;
  logic [7:0] evt_en;
  logic [7:0] flags_q;
  logic spare_input_level_flag;
  logic status_read;
  logic soft_clear;
  logic remote1_limit_flag;
  logic remote2_limit_flag;
  logic overheat_external_flag;
  logic spare_input_polarity_flip;
  logic next_alert_n;

  tism_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rb(rb)
  );

  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a == tism_pkg::reg_addr(idx));
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, tism_pkg::CFG_IDX) || hit(a, tism_pkg::STATUS_IDX) ||
      hit(a, tism_pkg::MASK_IDX) || hit(a, tism_pkg::EVT_IDX) ||
      hit(a, tism_pkg::EVT_EN_IDX);
  endfunction

  logic wr_lo;
  assign wr_lo = rb.wr_en && rb.wr_lane0;
  assign rb.wr_ok = mapped(rb.wr_addr);
  assign rb.rd_ok = mapped(rb.rd_addr);
  assign status_read = rb.rd_en && hit(rb.rd_addr, tism_pkg::STATUS_IDX);
  // soft reset bit is an action, never stored, so it reads back zero
  assign soft_clear = wr_lo && hit(rb.wr_addr, tism_pkg::CFG_IDX) &&
    rb.wr_data[tism_pkg::C_SOFT_RST];
  assign spare_input_polarity_flip = cfg[tism_pkg::C_POL_FLIP];
  assign monitor_start = cfg[tism_pkg::C_START];

  // cause inputs
  assign remote1_limit_flag = remote1_limit_hit;
  assign remote2_limit_flag = remote2_limit_hit;
  // only an outside party pulling the line counts, not our own driver
  assign overheat_external_flag = !overheat_line_n && !overheat_self_drive;
  assign spare_input_level_flag = spare_logic_input ^ spare_input_polarity_flip;

  always_comb begin
    cause_raw = 8'h00;
    cause_raw[tism_pkg::B_INT_LIMIT] = internal_limit_hit;
    cause_raw[tism_pkg::B_REMOTE2_LIMIT] = remote2_limit_flag;
    cause_raw[tism_pkg::B_REMOTE2_FAULT] = remote2_diode_fault;
    cause_raw[tism_pkg::B_REMOTE1_LIMIT] = remote1_limit_flag;
    cause_raw[tism_pkg::B_REMOTE1_FAULT] = remote1_diode_fault;
    cause_raw[tism_pkg::B_OVERHEAT_EXT] = overheat_external_flag;
  end

  tism_cause_latch u_latch (
    .aclk(aclk),
    .aresetn(aresetn),
    .cause_raw(cause_raw),
    .spare_level(spare_input_level_flag),
    .read_clear(status_read),
    .soft_clear(soft_clear),
    .cause_flags(irq_cause_flags)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= tism_pkg::CFG_RESET;
    end else if (soft_clear) begin
      cfg <= tism_pkg::CFG_RESET;
    end else if (wr_lo && hit(rb.wr_addr, tism_pkg::CFG_IDX)) begin
      cfg <= rb.wr_data & tism_pkg::CFG_WMASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_cause_gate <= tism_pkg::MASK_RESET;
    end else if (soft_clear) begin
      irq_cause_gate <= tism_pkg::MASK_RESET;
    end else if (wr_lo && hit(rb.wr_addr, tism_pkg::MASK_IDX)) begin
      irq_cause_gate <= rb.wr_data & tism_pkg::MASK_WMASK;
    end
  end

  // clear bit only releases the pin; status stays untouched
  assign next_alert_n = !(cfg[tism_pkg::C_INT_EN] && !cfg[tism_pkg::C_INT_CLR] &&
    |(irq_cause_flags & ~irq_cause_gate));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= next_alert_n;
    end
  end

  // sticky event bits on each rising cause flag, write one to clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= tism_pkg::STATUS_RESET;
    end else begin
      flags_q <= irq_cause_flags;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt <= tism_pkg::EVT_RESET;
    end else if (wr_lo && hit(rb.wr_addr, tism_pkg::EVT_IDX)) begin
      evt <= (evt & ~rb.wr_data) | (irq_cause_flags & ~flags_q);
    end else begin
      evt <= evt | (irq_cause_flags & ~flags_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_en <= tism_pkg::EVT_RESET;
    end else if (wr_lo && hit(rb.wr_addr, tism_pkg::EVT_EN_IDX)) begin
      evt_en <= rb.wr_data;
    end
  end

  assign irq = |(evt & evt_en);

  always_comb begin
    rb.rd_data = 8'h00;
    if (hit(rb.rd_addr, tism_pkg::CFG_IDX)) begin
      rb.rd_data = cfg;
    end else if (hit(rb.rd_addr, tism_pkg::STATUS_IDX)) begin
      rb.rd_data = irq_cause_flags;
    end else if (hit(rb.rd_addr, tism_pkg::MASK_IDX)) begin
      rb.rd_data = irq_cause_gate;
    end else if (hit(rb.rd_addr, tism_pkg::EVT_IDX)) begin
      rb.rd_data = evt;
    end else if (hit(rb.rd_addr, tism_pkg::EVT_EN_IDX)) begin
      rb.rd_data = evt_en;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_SRC_LATCH: assert property (
    !soft_clear |=> ((($past(cause_raw) & tism_pkg::LATCHED_BITS) & ~irq_cause_flags) == 8'h00))
    else $error("raised cause not latched into status");

  AST_SPARE_LIVE: assert property (
    irq_cause_flags[tism_pkg::B_SPARE_LEVEL] == (spare_logic_input ^ cfg[tism_pkg::C_POL_FLIP]))
    else $error("spare status bit not the live level");

  AST_SPARE_READ: assert property (
    status_read && irq_cause_flags[tism_pkg::B_SPARE_LEVEL] && $stable(spare_logic_input)
    ##1 $stable(spare_logic_input) && $stable(cfg)
    |-> irq_cause_flags[tism_pkg::B_SPARE_LEVEL])
    else $error("status read cleared spare bit");

  AST_RESET_VALUES: assert property (
    $rose(aresetn) |-> ((irq_cause_flags & tism_pkg::LATCHED_BITS) == 8'h00) &&
      (irq_cause_gate == 8'h00) && alert_n)
    else $error("status or mask not zero after reset");

  AST_MASK_BLOCKS: assert property (
    ((irq_cause_flags & ~irq_cause_gate) == 8'h00) |=> alert_n)
    else $error("masked status drove alert");

  AST_ENABLE_GATE: assert property (
    !cfg[tism_pkg::C_INT_EN] [*2] |-> alert_n)
    else $error("alert driven while disabled");

  AST_CLEAR_KEEPS: assert property (
    cfg[tism_pkg::C_INT_CLR] && !status_read && !soft_clear |=>
      alert_n && (($past(irq_cause_flags) & ~irq_cause_flags & tism_pkg::LATCHED_BITS) == 8'h00))
    else $error("interrupt clear lost status or kept alert");

  AST_SOFT_RESET: assert property (
    soft_clear |=> (irq_cause_gate == tism_pkg::MASK_RESET) && (cfg == tism_pkg::CFG_RESET) &&
      !cfg[tism_pkg::C_SOFT_RST] && ((irq_cause_flags & tism_pkg::LATCHED_BITS) == 8'h00))
    else $error("soft reset did not restore defaults");

  AST_ALERT_ON: assert property (
    cfg[tism_pkg::C_INT_EN] && !cfg[tism_pkg::C_INT_CLR] &&
    (|(irq_cause_flags & ~irq_cause_gate)) |=> !alert_n)
    else $error("alert not driven for unmasked status");

  AST_HOLD_UNTIL_READ: assert property (
    irq_cause_flags[tism_pkg::B_INT_LIMIT] && !status_read && !soft_clear |=>
      irq_cause_flags[tism_pkg::B_INT_LIMIT])
    else $error("latched bit lost without a read");

  AST_READ_CLEARS: assert property (
    status_read && !soft_clear && !internal_limit_hit |=> !irq_cause_flags[tism_pkg::B_INT_LIMIT])
    else $error("read did not clear a gone condition");

  // every latched bit, not just bit 0, keeps only what is still present at the read
  AST_READ_CLEARS_ALL: assert property (
    status_read && !soft_clear |=>
      ((irq_cause_flags & tism_pkg::LATCHED_BITS & ~$past(cause_raw)) == 8'h00))
    else $error("read left a gone condition latched");

  AST_HOLD_ALL: assert property (
    !status_read && !soft_clear |=>
      (($past(irq_cause_flags) & ~irq_cause_flags & tism_pkg::LATCHED_BITS) == 8'h00))
    else $error("latched status bit dropped without a read");

  // our own pull on the overheat line must never pass for an outside alarm
  AST_SELF_DRIVE: assert property (
    (overheat_line_n || overheat_self_drive) && !soft_clear &&
    (status_read || !irq_cause_flags[tism_pkg::B_OVERHEAT_EXT]) |=>
      !irq_cause_flags[tism_pkg::B_OVERHEAT_EXT])
    else $error("self driven overheat line latched as external");

  COV_ALERT: cover property (!alert_n ##1 alert_n);
  COV_SOFT: cover property (soft_clear);
  COV_STATUS_READ: cover property (status_read && irq_cause_flags != 8'h00);
  COV_IRQ: cover property (irq);
  COV_MASKED_HELD: cover property (irq_cause_flags[tism_pkg::B_REMOTE1_LIMIT] &&
    irq_cause_gate[tism_pkg::B_REMOTE1_LIMIT] && alert_n);
endmodule // tism_top

// *** test/tism_top_tb.sv ***
// self-checking bench for the thermal interrupt status and mask block
`timescale 1ns/1ps
module tism_top_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, self_drv, spare, mon_start, alert_n, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] cause;
  logic [15:0] rnd;
  int bad_count, checked, stat_m, mask_m, cfg_m, i;
  int src [$] = '{0, 1, 2, 5, 7, 6};

  tism_top i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .internal_limit_hit(cause[0]), .remote2_limit_hit(cause[1]),
    .remote2_diode_fault(cause[2]), .remote1_limit_hit(cause[5]),
    .remote1_diode_fault(cause[7]), .overheat_line_n(!cause[6]),
    .overheat_self_drive(self_drv), .spare_logic_input(spare),
    .monitor_start(mon_start), .alert_n(alert_n), .irq(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // both halves offered together, each dropped only at its own handshake edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st);
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h000000, d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no cycle budget here: only the watchdog may end a stuck wait
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] idx);
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic int exp_stat();
    return (stat_m & 8'hE7) | (int'(spare ^ cfg_m[6]) << 4);
  endfunction

  // latched bits survive a read only while their condition is still present
  task automatic rd_stat();
    rd_reg(tism_pkg::STATUS_IDX);
    chk(rd, exp_stat());
    stat_m &= {cause[7], cause[6] & !self_drv, cause[5], 2'h0, cause[2:0]};
  endtask

  task automatic pulse(input int b, input logic drv);
    @(posedge aclk);
    cause[b] <= 1'b1;
    self_drv <= drv;
    @(posedge aclk);
    cause[b] <= 1'b0;
    @(posedge aclk);
    self_drv <= 1'b0;
    if (b != 6 || !drv) stat_m |= 1 << b;
  endtask

  task automatic set_cfg(input logic [7:0] v);
    wr(tism_pkg::CFG_IDX, v, 4'hF);
    cfg_m = v & 8'hC7;
  endtask

  task automatic set_mask(input logic [7:0] v);
    wr(tism_pkg::MASK_IDX, v, 4'hF);
    mask_m = v & 8'hF7;
  endtask

  // alert is registered, so three edges cover the latch plus the output flop
  task automatic chk_out();
    int s;
    repeat (3) @(posedge aclk);
    s = exp_stat();
    chk(alert_n, !(cfg_m[1] && !cfg_m[2] && ((s & ~mask_m & 8'hFF) != 0)));
    chk(mon_start, cfg_m[0]);
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    #100000;
    bad_count++;
    end_sim();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, self_drv, spare} = 7'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    cause = 8'h00;
    rnd = 16'h9035;
    stat_m = 0;
    mask_m = 0;
    cfg_m = 8'h05;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_out();
    rd_stat();
    rd_reg(tism_pkg::MASK_IDX);
    chk(rd, 32'h00000000);
    rd_reg(tism_pkg::CFG_IDX);
    chk(rd, 32'h00000005);
    // every latched source, then a second read showing it cleared
    for (i = 0; i < src.size(); i++) begin
      pulse(src[i], 1'b0);
      rd_stat();
      rd_stat();
    end
    pulse(6, 1'b1);
    rd_stat();
    @(posedge aclk);
    cause[0] <= 1'b1;
    stat_m |= 1;
    rd_stat();
    rd_stat();
    @(posedge aclk);
    cause[0] <= 1'b0;
    rd_stat();
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      set_cfg({1'b0, rnd[0], 5'h00, rnd[2]});
      @(posedge aclk);
      spare <= rnd[1];
      repeat (2) @(posedge aclk);
      rd_stat();
      rd_stat();
      chk(mon_start, cfg_m[0]);
    end
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      set_mask(rnd[7:0]);
      chk(resp, tism_pkg::RESP_OKAY);
      rd_reg(tism_pkg::MASK_IDX);
      chk(rd, mask_m);
    end
    // a write with no byte lane enabled must leave the register alone
    wr(tism_pkg::MASK_IDX, ~rnd[7:0], 4'h0);
    chk(resp, tism_pkg::RESP_OKAY);
    rd_reg(tism_pkg::MASK_IDX);
    chk(rd, mask_m);
    @(posedge aclk);
    spare <= 1'b0;
    set_mask(8'h00);
    set_cfg(8'h03);
    chk_out();
    @(posedge aclk);
    cause[5] <= 1'b1;
    stat_m |= 8'h20;
    chk_out();
    // host masks the source that keeps firing while its condition stays
    set_mask(8'h20);
    chk_out();
    set_mask(8'hDF);
    chk_out();
    set_cfg(8'h07);
    chk_out();
    rd_stat();
    set_cfg(8'h03);
    chk_out();
    set_cfg(8'h01);
    chk_out();
    @(posedge aclk);
    cause[5] <= 1'b0;
    wr(tism_pkg::CFG_IDX, 8'h13, 4'hF);
    stat_m = 0;
    mask_m = 0;
    cfg_m = 8'h05;
    rd_reg(tism_pkg::CFG_IDX);
    chk(rd, 32'h00000005);
    rd_reg(tism_pkg::MASK_IDX);
    chk(rd, 32'h00000000);
    rd_stat();
    chk_out();
    // event flags feed the irq level through their enables
    wr(tism_pkg::EVT_IDX, 8'hFF, 4'hF);
    wr(tism_pkg::EVT_EN_IDX, 8'h01, 4'hF);
    chk(irq, 1'b0);
    pulse(0, 1'b0);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    rd_reg(tism_pkg::EVT_IDX);
    chk(rd & 32'h1, 32'h1);
    wr(tism_pkg::EVT_IDX, 8'h01, 4'hF);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    wr(tism_pkg::EVT_EN_IDX, 8'h00, 4'hF);
    rd_stat();
    pulse(0, 1'b0);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    wr(8'h50, 8'hA5, 4'hF);
    chk(resp, tism_pkg::RESP_SLVERR);
    rd_reg(8'h50);
    chk(resp, tism_pkg::RESP_SLVERR);
    chk(rd, 32'h00000000);
    end_sim();
  end
endmodule // tism_top_tb
